// [isr_status_reporting.v]
// status reporting: questionable, operation, standard event groups and output queue
// What this block does
// - questionable event register is read-only, latches, clears to zero when read
// - questionable condition register shows live state, reading changes nothing
// - questionable mask is 8-bit read/write; summary is OR of masked events
// - operation event register is read-only, latches, clears to zero when read
// - operation condition register shows live unlatched operation state
// - operation mask is 8-bit read/write; summary is OR of masked events
// - output queue keeps responses until read, first in first out
// - message available at status byte bit 4 while queue holds data
// - programming errors set standard event bits; reading clears that register
// - standard event mask selects bits ORed into status byte bit 5
// - bit 0 sets when operation-complete request finds operations finished
// - bit 2 sets on read of empty queue or lost queued data
// - bit 3 sets on lost memory or failed self-test
// - bit 4 sets on out-of-range, conflicting or unexecutable command
// - bit 5 sets on syntax or semantic error or trigger inside message
// - questionable summary sits at status byte bit 3
// - operation summary sits at status byte bit 7
// - condition bit set means condition true now, clear means false
`timescale 1ns/10ps
`include "isr_map.vh"
module isr_status_reporting (
   // clock and reset
   input wire clock,
   input wire resetn,
   // live conditions from the instrument
   input wire [7:0] questionable_live_state,
   input wire [7:0] operation_live_state,
   // host register access
   input wire reg_read,
   input wire reg_write,
   input wire [2:0] reg_sel,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   // error and completion events, one-cycle pulses; ops_pending is a level
   input wire opc_request,
   input wire ops_pending,
   input wire memory_lost,
   input wire self_test_fail,
   input wire param_error,
   input wire exec_error,
   input wire syntax_error,
   input wire trigger_in_message,
   // response queue fill side
   input wire resp_valid,
   input wire [7:0] resp_data,
   output reg resp_ready,
   // response queue drain side
   input wire resp_read,
   output reg [7:0] resp_rdata,
   output reg resp_rvalid,
   // status byte
   output reg [7:0] status_byte
);

   // ---------------------------------------------------------------
   // event groups
   // ---------------------------------------------------------------
   reg [7:0] questionable_summary_mask;
   reg [7:0] operation_summary_mask;
   reg [7:0] std_mask_q;
   wire [7:0] questionable_summary_flag_event;
   wire [7:0] operation_summary_flag_event;
   wire questionable_summary_flag;
   wire operation_summary_flag;
   wire rd_questionable_summary_flag_ev;
   wire rd_operation_summary_flag_ev;
   wire rd_std_ev;

   assign rd_questionable_summary_flag_ev = reg_read && (reg_sel == `ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_EVENT);
   assign rd_operation_summary_flag_ev = reg_read && (reg_sel == `ISR_SEL_OPERATION_SUMMARY_FLAG_EVENT);
   assign rd_std_ev = reg_read && (reg_sel == `ISR_SEL_STD_EVENT);

   isr_event_latch u_questionable_summary_flag (
      .clock(clock),
      .resetn(resetn),
      .cond(questionable_live_state),
      .read_clear(rd_questionable_summary_flag_ev),
      .mask(questionable_summary_mask),
      .event_q(questionable_summary_flag_event),
      .summary(questionable_summary_flag)
   );

   isr_event_latch u_operation_summary_flag (
      .clock(clock),
      .resetn(resetn),
      .cond(operation_live_state),
      .read_clear(rd_operation_summary_flag_ev),
      .mask(operation_summary_mask),
      .event_q(operation_summary_flag_event),
      .summary(operation_summary_flag)
   );

   // ---------------------------------------------------------------
   // output queue
   // ---------------------------------------------------------------
   reg [7:0] queue_mem [0:`ISR_QUEUE_DEPTH-1];
   reg [`ISR_QUEUE_AW-1:0] wr_ptr_q;
   reg [`ISR_QUEUE_AW-1:0] rd_ptr_q;
   reg [`ISR_QUEUE_AW:0] count_q;
   wire q_empty;
   wire q_full;
   wire q_push;
   wire q_pop;
   wire q_underrun;
   wire q_lost;

   assign q_empty = (count_q == {(`ISR_QUEUE_AW+1){1'b0}});
   assign q_full = (count_q == `ISR_QUEUE_DEPTH);
   assign q_pop = resp_read && !q_empty;
   assign q_push = resp_valid && !q_full;
   assign q_underrun = resp_read && q_empty;
   // a response offered while full is dropped and reported, not stalled forever
   assign q_lost = resp_valid && q_full;

   always @(posedge clock) begin
      if (q_push)
         queue_mem[wr_ptr_q] <= resp_data;
   end

   always @(posedge clock) begin
      if (!resetn) begin
         wr_ptr_q <= {`ISR_QUEUE_AW{1'b0}};
         rd_ptr_q <= {`ISR_QUEUE_AW{1'b0}};
         count_q <= {(`ISR_QUEUE_AW+1){1'b0}};
         resp_rdata <= `ISR_RST_BYTE;
         resp_rvalid <= 1'b0;
         resp_ready <= 1'b0;
      end else begin
         resp_rvalid <= q_pop;
         if (q_pop) begin
            resp_rdata <= queue_mem[rd_ptr_q];
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (q_push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         case ({q_push, q_pop})
            2'b10: count_q <= count_q + 1'b1;
            2'b01: count_q <= count_q - 1'b1;
            default: count_q <= count_q;
         endcase
         // ready is registered, so it reflects room after this cycle's moves
         case ({q_push, q_pop})
            2'b10: resp_ready <= (count_q + 1'b1) != `ISR_QUEUE_DEPTH;
            default: resp_ready <= !q_full || q_pop;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // standard event status
   // ---------------------------------------------------------------
   reg [7:0] std_event_q;
   reg [7:0] std_set;
   reg opc_wait_q;

   always @* begin
      std_set = `ISR_RST_BYTE;
      std_set[`ISR_STD_OPC] = (opc_request || opc_wait_q) && !ops_pending;
      std_set[`ISR_STD_QYE] = q_underrun || q_lost;
      std_set[`ISR_STD_DDE] = memory_lost || self_test_fail;
      std_set[`ISR_STD_EXE] = param_error || exec_error;
      std_set[`ISR_STD_CME] = syntax_error || trigger_in_message;
   end

   always @(posedge clock) begin
      if (!resetn) begin
         std_event_q <= `ISR_RST_BYTE;
         opc_wait_q <= 1'b0;
      end else begin
         // completion waits while operations remain pending
         if (opc_request || opc_wait_q)
            opc_wait_q <= ops_pending;
         // set wins over the read clear in the same cycle
         if (rd_std_ev)
            std_event_q <= std_set & `ISR_STD_USED_MASK;
         else
            std_event_q <= (std_event_q | std_set) & `ISR_STD_USED_MASK;
      end
   end

   // ---------------------------------------------------------------
   // host register access and status byte
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      if (!resetn) begin
         questionable_summary_mask <= `ISR_RST_BYTE;
         operation_summary_mask <= `ISR_RST_BYTE;
         std_mask_q <= `ISR_RST_BYTE;
         reg_rdata <= `ISR_RST_BYTE;
         reg_rvalid <= 1'b0;
         status_byte <= `ISR_RST_BYTE;
      end else begin
         if (reg_write) begin
            case (reg_sel)
               `ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_MASK: questionable_summary_mask <= reg_wdata;
               `ISR_SEL_OPERATION_SUMMARY_FLAG_MASK: operation_summary_mask <= reg_wdata;
               `ISR_SEL_STD_MASK: std_mask_q <= reg_wdata;
               default: ;
            endcase
         end
         reg_rvalid <= reg_read;
         if (reg_read) begin
            case (reg_sel)
               `ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_EVENT: reg_rdata <= questionable_summary_flag_event;
               `ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_COND: reg_rdata <= questionable_live_state;
               `ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_MASK: reg_rdata <= questionable_summary_mask;
               `ISR_SEL_OPERATION_SUMMARY_FLAG_EVENT: reg_rdata <= operation_summary_flag_event;
               `ISR_SEL_OPERATION_SUMMARY_FLAG_COND: reg_rdata <= operation_live_state;
               `ISR_SEL_OPERATION_SUMMARY_FLAG_MASK: reg_rdata <= operation_summary_mask;
               `ISR_SEL_STD_EVENT: reg_rdata <= std_event_q;
               default: reg_rdata <= std_mask_q;
            endcase
         end
         // one cycle behind the event registers; bits 0 to 2 and 6 are outside this block
         status_byte <= `ISR_RST_BYTE;
         status_byte[`ISR_STB_QUESTIONABLE_SUMMARY_FLAG] <= questionable_summary_flag;
         status_byte[`ISR_STB_MAV] <= !q_empty;
         status_byte[`ISR_STB_ESB] <= |(std_event_q & std_mask_q);
         status_byte[`ISR_STB_OPERATION_SUMMARY_FLAG] <= operation_summary_flag;
      end
   end

endmodule // isr_status_reporting

// [isr_map.vh]
// register selectors, field positions, reset values and sizes for status reporting
`ifndef ISR_MAP_VH
`define ISR_MAP_VH

// ---------------------------------------------------------------
// register selectors on the host access port
// ---------------------------------------------------------------
`define ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_EVENT 3'h0
`define ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_COND 3'h1
`define ISR_SEL_QUESTIONABLE_SUMMARY_FLAG_MASK 3'h2
`define ISR_SEL_OPERATION_SUMMARY_FLAG_EVENT 3'h3
`define ISR_SEL_OPERATION_SUMMARY_FLAG_COND 3'h4
`define ISR_SEL_OPERATION_SUMMARY_FLAG_MASK 3'h5
`define ISR_SEL_STD_EVENT 3'h6
`define ISR_SEL_STD_MASK 3'h7

// ---------------------------------------------------------------
// status byte bit positions
// ---------------------------------------------------------------
`define ISR_STB_QUESTIONABLE_SUMMARY_FLAG 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_OPERATION_SUMMARY_FLAG 7

// ---------------------------------------------------------------
// standard event bit positions
// ---------------------------------------------------------------
`define ISR_STD_OPC 0
`define ISR_STD_QYE 2
`define ISR_STD_DDE 3
`define ISR_STD_EXE 4
`define ISR_STD_CME 5
`define ISR_STD_USED_MASK 8'h3d

// ---------------------------------------------------------------
// reset values and queue size
// ---------------------------------------------------------------
`define ISR_RST_BYTE 8'h00
`define ISR_QUEUE_DEPTH 16
`define ISR_QUEUE_AW 4

`endif

// [isr_event_latch.v]
// one event group: rising-edge event latch with clear on read and masked summary
`timescale 1ns/10ps
`include "isr_map.vh"
module isr_event_latch (
   // clock and reset
   input wire clock,
   input wire resetn,
   // live condition
   input wire [7:0] cond,
   // host side
   input wire read_clear,
   input wire [7:0] mask,
   // results
   output reg [7:0] event_q,
   output wire summary
);

   reg [7:0] cond_q;
   wire [7:0] rise;

   assign rise = cond & ~cond_q;
   // summary uses the latched bits so it follows the event register
   assign summary = |(event_q & mask);

   always @(posedge clock) begin
      if (!resetn) begin
         cond_q <= `ISR_RST_BYTE;
         event_q <= `ISR_RST_BYTE;
      end else begin
         cond_q <= cond;
         // a new edge in the clearing cycle survives the clear
         if (read_clear)
            event_q <= rise;
         else
            event_q <= event_q | rise;
      end
   end

endmodule // isr_event_latch

// [isr_properties.sv]
// port-level checker for the status reporting block
`timescale 1ns/10ps
module isr_properties (
   // clock and reset
   input wire clock,
   input wire resetn,
   // live states and host port
   input wire [7:0] questionable_live_state,
   input wire [7:0] operation_live_state,
   input wire reg_read,
   input wire reg_write,
   input wire [2:0] reg_sel,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire reg_rvalid,
   // queue and status
   input wire resp_valid,
   input wire resp_ready,
   input wire [7:0] status_byte
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   property p_rv; reg_rvalid == $past(reg_read); endproperty
   a_rv: assert property (p_rv) else $error("read answer timing");
   property p_qc; reg_read && reg_sel == 3'h1 |=> reg_rdata == $past(questionable_live_state);
   endproperty
   a_qc: assert property (p_qc) else $error("live questionable state");
   property p_oc; reg_read && reg_sel == 3'h4 |=> reg_rdata == $past(operation_live_state);
   endproperty
   a_oc: assert property (p_oc) else $error("live operation state");
   property p_qe; (reg_read && reg_sel == 3'h0 && $stable(questionable_live_state)) [*2]
      |=> reg_rdata == 8'h00; endproperty
   a_qe: assert property (p_qe) else $error("questionable events not cleared");
   property p_oe; (reg_read && reg_sel == 3'h3 && $stable(operation_live_state)) [*2]
      |=> reg_rdata == 8'h00; endproperty
   a_oe: assert property (p_oe) else $error("operation events not cleared");
   property p_mk; reg_write && (reg_sel == 3'h2 || reg_sel == 3'h5) ##2 reg_read
      && !reg_write && !$past(reg_write) && reg_sel == $past(reg_sel, 2)
      |=> reg_rdata == $past(reg_wdata, 3); endproperty
   a_mk: assert property (p_mk) else $error("mask readback");
   property p_sz; reg_read && reg_sel == 3'h6 |=> (reg_rdata & 8'hc2) == 8'h00; endproperty
   a_sz: assert property (p_sz) else $error("unused event bits set");
   property p_sb; (status_byte & 8'h47) == 8'h00; endproperty
   a_sb: assert property (p_sb) else $error("unused status bits set");
   property p_ma; $rose(status_byte[4]) |-> $past(resp_valid && resp_ready, 2); endproperty
   a_ma: assert property (p_ma) else $error("message flag without push");
endmodule // isr_properties
bind isr_status_reporting isr_properties u_props (.clock, .resetn, .questionable_live_state,
   .operation_live_state, .reg_read, .reg_write, .reg_sel, .reg_wdata, .reg_rdata,
   .reg_rvalid, .resp_valid, .resp_ready, .status_byte);

// [isr_host_model.sv]
// host model that pops the response queue and counts answers
`timescale 1ns/10ps
module isr_host_model (
   // clock
   input wire clock,
   // pop request, random gaps give a slow host
   input wire go,
   // queue drain side
   output logic resp_read,
   input wire resp_rvalid,
   // answers seen
   output int seen
);
   initial resp_read = 1'b0;
   initial seen = 0;
   always @(posedge clock) begin
      resp_read <= go;
      if (resp_rvalid) seen <= seen + 1;
   end
endmodule // isr_host_model

// [tb_top.sv]
// self-checking bench for status reporting
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %0t got %h expected %h", $time, a, e); end end
module tb_top;
   logic clock = 1'b0, resetn = 1'b0, reg_read = 1'b0, reg_write = 1'b0;
   logic resp_valid = 1'b0, go = 1'b0, ops_pending = 1'b0, opc_request = 1'b0;
   logic [7:0] qls = 8'h00, ols = 8'h00, reg_wdata = 8'h00, resp_data = 8'h00;
   logic [2:0] reg_sel = 3'h0;
   logic [5:0] ev = 6'h00;
   logic [7:0] reg_rdata, resp_rdata, status_byte, r, m, k, pv;
   logic reg_rvalid, resp_ready, resp_rvalid, resp_read;
   int fails = 0, total_checks = 0, seen, cyc = 0;
   logic [7:0] q[$];
   always #25 clock = ~clock;
   isr_status_reporting DUT (.clock, .resetn, .questionable_live_state(qls),
      .operation_live_state(ols), .reg_read, .reg_write, .reg_sel, .reg_wdata, .reg_rdata,
      .reg_rvalid, .opc_request, .ops_pending, .memory_lost(ev[0]), .self_test_fail(ev[1]),
      .param_error(ev[2]), .exec_error(ev[3]), .syntax_error(ev[4]),
      .trigger_in_message(ev[5]), .resp_valid, .resp_data, .resp_ready, .resp_read,
      .resp_rdata, .resp_rvalid, .status_byte);
   isr_host_model host (.clock, .go, .resp_read, .resp_rvalid, .seen);
   // ---------------------------------------------------------------
   // queue model, compared at every popped byte
   // ---------------------------------------------------------------
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin fails++; print_verdict; end
      if (resp_valid && resp_ready) q.push_back(resp_data);
      if (resp_rvalid) begin pv = q.pop_front(); `CHK(resp_rdata, pv) end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic rd(input [2:0] s, input int n, input [7:0] e);
      @(posedge clock) begin reg_read <= 1'b1; reg_sel <= s; end
      repeat (n) @(posedge clock);
      reg_read <= 1'b0;
      #1 `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
   endtask
   task automatic wr(input [2:0] s, input [7:0] d);
      @(posedge clock) begin reg_write <= 1'b1; reg_sel <= s; reg_wdata <= d; end
      @(posedge clock) reg_write <= 1'b0;
   endtask
   task automatic st(input int b, input logic e);
      repeat (3) @(posedge clock);
      #1 `CHK(status_byte[b], e)
   endtask
   task automatic lv(input [2:0] b, input [7:0] v);
      @(posedge clock) if (b == 3'h0) qls <= v; else ols <= v;
   endtask
   // one event group: latch, hold after condition drops, mask, clear on read
   task automatic grp(input [2:0] b, input int sb, input [7:0] mk);
      r = 8'($urandom) | 8'h01;
      lv(b, r);
      repeat (2) @(posedge clock);
      lv(b, 8'h00);
      wr(b + 3'h1, 8'h5a);
      wr(b + 3'h2, mk);
      rd(b + 3'h2, 1, mk);
      st(sb, |(r & mk));
      rd(b + 3'h1, 1, 8'h00);
      rd(b, 1, r);
      rd(b, 2, 8'h00);
      st(sb, 1'b0);
      lv(b, r);
      rd(b + 3'h1, 1, r);
      rd(b, 1, r);
      lv(b, 8'h00);
      $display("group %0d done", b);
   endtask
   initial begin
      void'($urandom(12930));
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      rd(3'h2, 1, 8'h00);
      grp(3'h0, 3, 8'($urandom));
      grp(3'h3, 7, 8'($urandom));
      grp(3'h0, 3, 8'hff);
      grp(3'h3, 7, 8'hff);
      for (int i = 0; i < 6; i++) begin
         m = 8'h08 << (i / 2);
         k = 8'($urandom);
         wr(3'h7, k);
         @(posedge clock) ev <= 6'h01 << i;
         @(posedge clock) ev <= 6'h00;
         st(5, |(m & k));
         rd(3'h6, 1, m);
         rd(3'h6, 1, 8'h00);
      end
      $display("standard events done");
      @(posedge clock) begin ops_pending <= 1'b1; opc_request <= 1'b1; end
      @(posedge clock) opc_request <= 1'b0;
      rd(3'h6, 1, 8'h00);
      @(posedge clock) ops_pending <= 1'b0;
      repeat (2) @(posedge clock);
      rd(3'h6, 1, 8'h01);
      $display("operation complete done");
      for (int i = 0; i < 17; i++)
         @(posedge clock) begin resp_valid <= 1'b1; resp_data <= 8'($urandom); end
      @(posedge clock) resp_valid <= 1'b0;
      st(4, 1'b1);
      `CHK(resp_ready, 1'b0)
      `CHK(q.size(), 16)
      rd(3'h6, 1, 8'h04);
      while (seen < 16) @(posedge clock) go <= 1'($urandom);
      @(posedge clock) go <= 1'b1;
      @(posedge clock) go <= 1'b0;
      repeat (4) @(posedge clock);
      `CHK(seen, 16)
      rd(3'h6, 1, 8'h04);
      st(4, 1'b0);
      $display("queue done");
      print_verdict;
   end
endmodule // tb_top
